// ==== hw/sstp_map.vh ====
// Register offsets, field positions, reset values and limits of the status telegram packer
`ifndef SSTP_MAP_VH
`define SSTP_MAP_VH

// Register word indices on the bus, taken from byte address bits 5..2
`define SSTP_REG_CTRL       4'h0
`define SSTP_REG_SCAN_CNT   4'h1
`define SSTP_REG_WORD_A     4'h2
`define SSTP_REG_WORD_B     4'h3
`define SSTP_REG_IRQ_STAT   4'h4
`define SSTP_REG_IRQ_CLR    4'h5
`define SSTP_REG_IRQ_EN     4'h6
`define SSTP_REG_FRAME_LO   4'h7

// Control register fields
`define SSTP_CTRL_FUNC_A_EN 0
`define SSTP_CTRL_FUNC_B_EN 1
`define SSTP_CTRL_RESET     8'h03

// Status byte fields, same layout for both functions
`define SSTP_ST_ACTIVE      7
`define SSTP_ST_WARN        6
`define SSTP_ST_GUARD       5
`define SSTP_ST_RESTART     4
`define SSTP_ST_OUTPUT      3

// Segment byte fields
`define SSTP_SG_WARN1       7
`define SSTP_SG_WARN2       6
`define SSTP_SG_GUARD1      5
`define SSTP_SG_GUARD2      4
`define SSTP_SG_PAIR1       3
`define SSTP_SG_PAIR2       2

// Interrupt bits
`define SSTP_IRQ_SCAN       0
`define SSTP_IRQ_GUARD      1
`define SSTP_IRQ_RANGE      2
`define SSTP_IRQ_WIDTH      3

// Legal range of bank and pair numbers
`define SSTP_NUM_MIN        4'h1
`define SSTP_NUM_MAX        4'hA

// Telegram geometry
`define SSTP_FIRST_BYTE     12
`define SSTP_LAST_BYTE      19
`define SSTP_TELE_BYTES     20

`endif

// ==== hw/sstp_packer.v ====
// Scanner status telegram packer: scan counter, function A/B status bytes, Wishbone registers
//
// Notes on behaviour
// - Unsigned 32-bit scan counter numbers successive scans; value goes in each telegram.
// - Scan counter clears only at power removal; otherwise it returns to zero only on wrapping past 2^32-1.
// - Byte 12 bit 7 is one when function A configured and active.
// - Byte 12 bit 6 shows A warning field: zero violated, one free.
// - Byte 12 bit 5 shows A protective field: zero violated, one free.
// - Byte 12 bit 4 is one while A restart interlock requests a start.
// - Byte 12 bit 3 mirrors A internal safety output, one meaning on.
// - Byte 13 holds A bank number high nibble, first pair low nibble.
// - Byte 14 holds A second pair high nibble, third pair low nibble.
// - Byte 15 bits 7..4 hold A warning and guard segment states.
// - Byte 15 bits 3 and 2 show A first and second pair selected.
// - Bytes 16 to 19 report function B with function A layout.
// - Byte 16 bit 4 is one while B restart interlock requests a start.
// - Byte 16 bit 3 mirrors B internal safety output, one meaning on.
// - Byte 17 holds B bank number high nibble, first pair low nibble.
`include "sstp_map.vh"

module sstp_packer #(
	parameter CNT_W = 32,
	parameter NIB_W = 4
) (
	// Clock, reset, enable
	input  wire              clk,
	input  wire              reset,
	input  wire              clk_en,
	// Scan results from field evaluation, taken when scan_done is high
	input  wire              scan_done,
	input  wire              func_a_configured,
	input  wire              func_a_warning_zone_state,
	input  wire              func_a_guard_zone_state,
	input  wire              func_a_restart_lock,
	input  wire              func_a_safety_switching_output,
	input  wire [NIB_W-1:0]  func_a_bank_sel,
	input  wire [NIB_W-1:0]  func_a_pair1_sel,
	input  wire [NIB_W-1:0]  func_a_pair2_sel,
	input  wire [NIB_W-1:0]  func_a_pair3_sel,
	input  wire              func_a_warning_segment1_state,
	input  wire              func_a_warning_segment2_state,
	input  wire              func_a_guard_segment1_state,
	input  wire              func_a_guard_segment2_state,
	input  wire              func_a_pair1_selected,
	input  wire              func_a_pair2_selected,
	input  wire              func_b_configured,
	input  wire              func_b_warning_zone_state,
	input  wire              func_b_guard_zone_state,
	input  wire              func_b_restart_lock,
	input  wire              func_b_safety_switching_output,
	input  wire [NIB_W-1:0]  func_b_bank_sel,
	input  wire [NIB_W-1:0]  func_b_pair1_sel,
	input  wire [NIB_W-1:0]  func_b_pair2_sel,
	input  wire [NIB_W-1:0]  func_b_pair3_sel,
	input  wire              func_b_warning_segment1_state,
	input  wire              func_b_warning_segment2_state,
	input  wire              func_b_guard_segment1_state,
	input  wire              func_b_guard_segment2_state,
	input  wire              func_b_pair1_selected,
	input  wire              func_b_pair2_selected,
	// Telegram out, bytes 0..3 counter, 12..15 function A, 16..19 function B
	output reg  [CNT_W-1:0]  scan_count,
	output reg  [31:0]       tele_func_a,
	output reg  [31:0]       tele_func_b,
	output reg               tele_valid,
	// Wishbone classic slave
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [5:0]        wb_adr_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	output reg               wb_ack_o,
	output wire              wb_err_o,
	// Interrupt
	output wire              irq
);

	////////////////////////////////////////////////////////////////////////////
	// Register state

	reg  [7:0]  ctrl;
	reg  [3:0]  irq_stat;
	reg  [3:0]  irq_en;
	reg         first_done;
	reg  [3:0]  next_irq_stat;
	wire [3:0]  scan_events;
	wire [3:0]  clr_bits;

	wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [3:0] widx = wb_adr_i[5:2];
	wire wr_hit  = req & wb_we_i & wb_sel_i[0];

	////////////////////////////////////////////////////////////////////////////
	// Field packing, function A and B share one layout

	// Numbers outside 1..10 of an active function are flagged but passed unchanged so faults stay visible
	function range_bad;
		input [NIB_W-1:0] n;
		begin
			range_bad = (n < `SSTP_NUM_MIN) || (n > `SSTP_NUM_MAX);
		end
	endfunction

	// Status byte; low three bits are reserved and sent as zero
	function [7:0] pack_status;
		input act, warn, guard, rst, outp;
		begin
			pack_status = 8'h00;
			pack_status[`SSTP_ST_ACTIVE]  = act;
			pack_status[`SSTP_ST_WARN]    = warn;
			pack_status[`SSTP_ST_GUARD]   = guard;
			pack_status[`SSTP_ST_RESTART] = rst;
			pack_status[`SSTP_ST_OUTPUT]  = outp;
		end
	endfunction

	// Segment byte; bits 1..0 reserved
	function [7:0] pack_segments;
		input w1, w2, g1, g2, p1, p2;
		begin
			pack_segments = 8'h00;
			pack_segments[`SSTP_SG_WARN1]  = w1;
			pack_segments[`SSTP_SG_WARN2]  = w2;
			pack_segments[`SSTP_SG_GUARD1] = g1;
			pack_segments[`SSTP_SG_GUARD2] = g2;
			pack_segments[`SSTP_SG_PAIR1]  = p1;
			pack_segments[`SSTP_SG_PAIR2]  = p2;
		end
	endfunction

	// A function counts as active only when software enables it and evaluation reports it configured
	wire act_a = func_a_configured & ctrl[`SSTP_CTRL_FUNC_A_EN];
	wire act_b = func_b_configured & ctrl[`SSTP_CTRL_FUNC_B_EN];

	wire [31:0] word_a = {
		pack_status(act_a, func_a_warning_zone_state, func_a_guard_zone_state,
			func_a_restart_lock, func_a_safety_switching_output),
		func_a_bank_sel, func_a_pair1_sel,
		func_a_pair2_sel, func_a_pair3_sel,
		pack_segments(func_a_warning_segment1_state, func_a_warning_segment2_state,
			func_a_guard_segment1_state, func_a_guard_segment2_state,
			func_a_pair1_selected, func_a_pair2_selected)};

	// Same layout for B, bytes 16..19
	wire [31:0] word_b = {
		pack_status(act_b, func_b_warning_zone_state, func_b_guard_zone_state,
			func_b_restart_lock, func_b_safety_switching_output),
		func_b_bank_sel, func_b_pair1_sel,
		func_b_pair2_sel, func_b_pair3_sel,
		pack_segments(func_b_warning_segment1_state, func_b_warning_segment2_state,
			func_b_guard_segment1_state, func_b_guard_segment2_state,
			func_b_pair1_selected, func_b_pair2_selected)};

	wire range_err =
		(act_a & (range_bad(func_a_bank_sel) | range_bad(func_a_pair1_sel) |
			range_bad(func_a_pair2_sel) | range_bad(func_a_pair3_sel))) |
		(act_b & (range_bad(func_b_bank_sel) | range_bad(func_b_pair1_sel) |
			range_bad(func_b_pair2_sel) | range_bad(func_b_pair3_sel)));

	////////////////////////////////////////////////////////////////////////////
	// Scan counter and telegram capture

	// Reset is the power-on reset only; there is deliberately no software clear path
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			scan_count <= {CNT_W{1'b0}};
			tele_func_a <= 32'h0000_0000;
			tele_func_b <= 32'h0000_0000;
			tele_valid <= 1'b0;
			first_done <= 1'b0;
		end else if (clk_en) begin
			tele_valid <= scan_done;
			if (scan_done) begin
				// First scan is numbered zero, each later scan one more; wraps at 2^32
				if (first_done) begin
					scan_count <= scan_count + {{(CNT_W-1){1'b0}}, 1'b1};
				end
				first_done <= 1'b1;
				tele_func_a <= word_a;
				tele_func_b <= word_b;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over clear

	assign scan_events[`SSTP_IRQ_SCAN]  = scan_done;
	assign scan_events[`SSTP_IRQ_GUARD] = scan_done &
		((act_a & ~func_a_guard_zone_state) | (act_b & ~func_b_guard_zone_state));
	assign scan_events[`SSTP_IRQ_RANGE] = scan_done & range_err;
	assign scan_events[`SSTP_IRQ_WIDTH] = scan_done & first_done & (&scan_count);
	assign clr_bits = (wr_hit && widx == `SSTP_REG_IRQ_CLR) ? wb_dat_i[3:0] : 4'h0;

	// Status update
	always @* begin
		next_irq_stat = (irq_stat & ~clr_bits) | scan_events;
	end

	assign irq = |(irq_stat & irq_en);

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave, one registered answer per request, ack one cycle after the request is sampled

	assign wb_err_o = 1'b0;

	// Writes act at the ack edge; ack drops the cycle after
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl <= `SSTP_CTRL_RESET;
			irq_en <= 4'h0;
			irq_stat <= 4'h0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (clk_en) begin
			irq_stat <= next_irq_stat;
			wb_ack_o <= req;
			if (wr_hit) begin
				if (widx == `SSTP_REG_CTRL) begin
					ctrl <= wb_dat_i[7:0];
				end else if (widx == `SSTP_REG_IRQ_EN) begin
					irq_en <= wb_dat_i[3:0];
				end
			end
			if (req & ~wb_we_i) begin
				if (widx == `SSTP_REG_CTRL) begin
					wb_dat_o <= {24'h00_0000, ctrl};
				end else if (widx == `SSTP_REG_SCAN_CNT) begin
					wb_dat_o <= scan_count;
				end else if (widx == `SSTP_REG_WORD_A) begin
					wb_dat_o <= tele_func_a;
				end else if (widx == `SSTP_REG_WORD_B) begin
					wb_dat_o <= tele_func_b;
				end else if (widx == `SSTP_REG_IRQ_STAT) begin
					wb_dat_o <= {28'h000_0000, irq_stat};
				end else if (widx == `SSTP_REG_IRQ_EN) begin
					wb_dat_o <= {28'h000_0000, irq_en};
				end else if (widx == `SSTP_REG_FRAME_LO) begin
					wb_dat_o <= {{31{1'b0}}, first_done};
				end else begin
					wb_dat_o <= 32'h0000_0000;            // Unmapped and write-only read zero
				end
			end
		end
	end

endmodule // sstp_packer

// ==== tb/sstp_packer_sva.sv ====
// Assertion checker for the status telegram packer, bound to its ports
module sstp_chk #(
	parameter CNT_W = 32
) (
	// Clock and reset
	input logic             clk,
	input logic             reset,
	// Scan inputs
	input logic             clk_en,
	input logic             scan_done,
	input logic             func_a_restart_lock,
	input logic             func_b_restart_lock,
	input logic             func_a_safety_switching_output,
	input logic             func_b_safety_switching_output,
	// Telegram outputs
	input logic [CNT_W-1:0] scan_count,
	input logic [31:0]      tele_func_a,
	input logic [31:0]      tele_func_b,
	input logic             tele_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire take = scan_done && clk_en;
	// First telegram seen; the count step is only defined after it
	logic seen;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			seen <= 1'b0;
		else if (tele_valid)
			seen <= 1'b1;
	end
	property p_valid; take |=> tele_valid; endproperty
	a_valid: assert property (p_valid) else $error("no telegram after scan");
	property p_step; take && seen |=> scan_count == $past(scan_count) + 1'b1; endproperty
	a_step: assert property (p_step) else $error("scan count did not step");
	property p_hold; !take |=> $stable(scan_count); endproperty
	a_hold: assert property (p_hold) else $error("scan count moved without scan");
	property p_func_a_restart_lock; take |=> tele_func_a[28] == $past(func_a_restart_lock); endproperty
	a_func_a_restart_lock: assert property (p_func_a_restart_lock) else $error("restart bit A wrong");
	property p_func_b_restart_lock; take |=> tele_func_b[28] == $past(func_b_restart_lock); endproperty
	a_func_b_restart_lock: assert property (p_func_b_restart_lock) else $error("restart bit B wrong");
	property p_a_out; take |=> tele_func_a[27] == $past(func_a_safety_switching_output); endproperty
	a_a_out: assert property (p_a_out) else $error("output bit A wrong");
	property p_b_out; take |=> tele_func_b[27] == $past(func_b_safety_switching_output); endproperty
	a_b_out: assert property (p_b_out) else $error("output bit B wrong");
	property p_rsv; ((tele_func_a | tele_func_b) & 32'h0700_0003) == 32'h0000_0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_first; !seen && !tele_valid |-> (tele_func_a | tele_func_b) == 32'h0000_0000; endproperty
	a_first: assert property (p_first) else $error("telegram not zero before scan");
endmodule // sstp_chk

bind sstp_packer sstp_chk #(.CNT_W(CNT_W)) u_chk (.clk, .reset, .clk_en, .scan_done, .func_a_restart_lock,
	.func_b_restart_lock, .func_a_safety_switching_output, .func_b_safety_switching_output, .scan_count,
	.tele_func_a, .tele_func_b, .tele_valid);

// ==== tb/sstp_rx.sv ====
// Receiver model: latches the scan counter of each telegram the packer sends
module sstp_rx (
	// Clock and reset
	input  logic        clk,
	input  logic        reset,
	// Telegram in
	input  logic        tele_valid,
	input  logic [31:0] scan_count,
	// Last telegram counter taken
	output logic [31:0] rx_cnt
);
	// Words are only trusted on the valid pulse
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rx_cnt <= 32'h0000_0000;
		else if (tele_valid)
			rx_cnt <= scan_count;
	end
endmodule // sstp_rx

// ==== tb/sstp_packer_tb_top.sv ====
// Self-checking bench for the status telegram packer
module scanner_status_telegram_packer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, reset = 1, sd = 0, cyc = 0, stb = 0, we = 0, ce = 1;
	logic [5:0]  adr = '0;
	logic [1:0]  en = 2'b11;
	logic [31:0] dat = '0, q, r, seed = 32'h2084_f03b, cnt_e = '0;
	logic [26:0] a = '0, b = '0;
	wire  [31:0] cnt, tfa, tfb, rd, rxc;
	wire         tv, ack, irq;
	integer      mismatches = 0, n_checks = 0, n;
	always #2 clk = ~clk;
	sstp_packer u_dut (.clk(clk), .reset(reset), .clk_en(ce), .scan_done(sd),
		.func_a_configured(a[26]), .func_a_warning_zone_state(a[25]), .func_a_guard_zone_state(a[24]),
		.func_a_restart_lock(a[23]), .func_a_safety_switching_output(a[22]), .func_a_bank_sel(a[21:18]),
		.func_a_pair1_sel(a[17:14]), .func_a_pair2_sel(a[13:10]), .func_a_pair3_sel(a[9:6]),
		.func_a_warning_segment1_state(a[5]), .func_a_warning_segment2_state(a[4]),
		.func_a_guard_segment1_state(a[3]), .func_a_guard_segment2_state(a[2]),
		.func_a_pair1_selected(a[1]), .func_a_pair2_selected(a[0]),
		.func_b_configured(b[26]), .func_b_warning_zone_state(b[25]), .func_b_guard_zone_state(b[24]),
		.func_b_restart_lock(b[23]), .func_b_safety_switching_output(b[22]), .func_b_bank_sel(b[21:18]),
		.func_b_pair1_sel(b[17:14]), .func_b_pair2_sel(b[13:10]), .func_b_pair3_sel(b[9:6]),
		.func_b_warning_segment1_state(b[5]), .func_b_warning_segment2_state(b[4]),
		.func_b_guard_segment1_state(b[3]), .func_b_guard_segment2_state(b[2]),
		.func_b_pair1_selected(b[1]), .func_b_pair2_selected(b[0]),
		.scan_count(cnt), .tele_func_a(tfa), .tele_func_b(tfb), .tele_valid(tv),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(), .irq(irq));
	sstp_rx u_rx (.clk(clk), .reset(reset), .tele_valid(tv), .scan_count(cnt), .rx_cnt(rxc));
	//////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Numbers kept in 1..10, the range the packer accepts without flagging
	function automatic logic [26:0] mk(input logic [31:0] v);
		return {v[31:27], 4'h1 + v[3:0] % 4'ha, 4'h1 + v[7:4] % 4'ha, 4'h1 + v[11:8] % 4'ha,
			4'h1 + v[15:12] % 4'ha, v[21:16]};
	endfunction
	// Expected function word: active needs the control enable too
	function automatic logic [31:0] ex(input logic [26:0] v, input logic e);
		return {v[26] & e, v[25:22], 3'b000, v[21:6], v[5:0], 2'b00};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	task give_verdict;
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Classic single cycle; request held until ack is sampled high
	task wb(input logic w, input logic [5:0] ad, input logic [31:0] d);
		integer k;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= ad;
		dat <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rd;
		cyc <= 0;
		stb <= 0;
		if (k >= 20) begin
			mismatches++;
			give_verdict;
		end
	endtask
	task scan(input logic [26:0] va, input logic [26:0] vb);
		@(posedge clk);
		a <= va;
		b <= vb;
		sd <= 1;
		@(posedge clk);
		sd <= 0;
		// Look once the launching edge has settled, not in its own time step
		#1;
		chk(tv, 1);
		chk(cnt, cnt_e);
		chk(tfa, ex(va, en[0]));
		chk(tfb, ex(vb, en[1]));
		@(posedge clk);
		#1;
		chk(rxc, cnt_e);
		cnt_e++;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		chk(tfa | tfb | cnt | tv | irq, 0);
		wb(0, 6'h00, 0);
		chk(q, 32'h0000_0003);
		wb(0, 6'h20, 0);
		chk(q, 0);
		wb(1, 6'h18, 32'h0000_0001);
		scan({5'h1f, 16'haaaa, 6'h3f}, {5'h00, 16'h1111, 6'h00});
		chk(irq, 1);
		wb(0, 6'h04, 0);
		chk(q, cnt_e - 1);
		wb(0, 6'h08, 0);
		chk(q, ex(a, 1'b1));
		wb(1, 6'h14, 32'h0000_000f);
		chk(irq, 0);
		wb(1, 6'h00, 32'h0000_0002);
		en = 2'b10;
		// Random scans, function A disabled by control then both enabled
		for (n = 0; n < 40; n++) begin
			if (n == 20) begin
				wb(1, 6'h00, 32'h0000_0003);
				en = 2'b11;
			end
			seed = xs(seed);
			r = seed;
			seed = xs(seed);
			scan(mk(r), mk(seed));
		end
		chk(irq, 1);
		// Scan pulse while the enable is low must leave everything frozen
		@(posedge clk);
		ce <= 0;
		sd <= 1;
		@(posedge clk);
		sd <= 0;
		@(posedge clk);
		ce <= 1;
		#1;
		chk(tv, 0);
		chk(cnt, cnt_e - 1);
		wb(0, 6'h1c, 0);
		chk(q, 1);
		wb(1, 6'h18, 0);
		chk(irq, 0);
		wb(0, 6'h10, 0);
		chk(q[0], 1);
		give_verdict;
	end
endmodule // scanner_status_telegram_packer_tb_top
